// ===== fpec_regs.vh
`ifndef FPEC_REGS_VH
`define FPEC_REGS_VH
// special-function register offsets
`define FPEC_SECT_HIGH_ADDR 8'hfa
`define FPEC_SECT_MID_ADDR  8'hfb
`define FPEC_SECT_LOW_ADDR  8'hfc
`define FPEC_KEY_ADDR       8'hfd
`define FPEC_CTRL_ADDR      8'hfe
// reset values
`define FPEC_REG_RESET      8'h00
// key pattern
`define FPEC_KEY_ARMED      8'ha5
// operation_control fields
`define FPEC_BUSY_BIT       7
`define FPEC_OP_MSB         2
`define FPEC_OP_CLEAR_BUF   3'h1
`define FPEC_OP_ERASE       3'h2
`define FPEC_OP_WRITE       3'h3
`define FPEC_OP_HARD_LOCK   3'h4
// page buffer window in external data space
`define FPEC_PBUF_BASE_HI   10'h200
`define FPEC_PBUF_BYTES     64
// protected region
`define FPEC_PROT_LOW       16'h0100
`define FPEC_PROT_TOP_00    16'h0fff
`define FPEC_PROT_TOP_01    16'h07ff
`define FPEC_PROT_TOP_10    16'h03ff
`define FPEC_PROT_TOP_11    16'h01ff
// timing
`define FPEC_OP_TIME_NS     1000
`define FPEC_CLK_PERIOD_NS  10
`endif

// ===== fpec_page_buffer.v
`timescale 1ns/1ns
module fpec_page_buffer #(
  parameter DEPTH = 64,
  parameter AW    = 6
) (
  // clock and reset
  input  wire          core_clk,
  input  wire          nrst,
  // control
  input  wire          clear_all,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_idx,
  input  wire [7:0]    wr_data,
  // contents
  output wire [DEPTH*8-1:0] data_flat,
  output wire [DEPTH-1:0]   loaded_flat
);
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_byte
      reg [7:0] byte_r;
      reg       loaded_r;
      always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          byte_r   <= 8'h00;
          loaded_r <= 1'b0;
        end else if (clear_all) begin
          byte_r   <= 8'h00;
          loaded_r <= 1'b0;
        end else if (wr_en && wr_idx == g) begin
          byte_r   <= wr_data;
          loaded_r <= 1'b1;
        end
      end
      assign data_flat[g*8 +: 8] = byte_r;
      assign loaded_flat[g]      = loaded_r;
    end
  endgenerate
endmodule

// ===== fpec_ctrl.v
`timescale 1ns/1ns
`include "fpec_regs.vh"
// Behaviour
// - control registers accept writes only while programming mode is on
// - key counts as armed only when it holds 10100101
// - key returns to zero when any nonzero select is written while idle
// - select 001 clears all 64 buffer bytes, key not needed
// - select 010 with armed key erases the addressed sector
// - select 011 with armed key programs sector from page buffer
// - select 100 with armed key performs hard lock
// - other selects start no operation; select field self-clears after operation
// - cpu stalled and interrupts forced off while operation runs
// - bit 7 busy flag reads 1 while busy, writes ignored
// - sector address from 4-bit high plus middle and low bytes
// - enabled protection refuses erase or program inside region
// - two-bit option sets protected region top address
// - 64-byte page buffer written via external data at 0x8000
// - only loaded buffer bytes change matching sector bytes
// - code reads return flash contents without key or mode
// - protection option bit 1 enables region, 0 leaves it erasable
module fpec_ctrl #(
  parameter DEPTH  = `FPEC_PBUF_BYTES,
  parameter AW     = 6,
  parameter OP_CYC = (`FPEC_OP_TIME_NS + `FPEC_CLK_PERIOD_NS - 1)
                     / `FPEC_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        nrst,
  // special-function register port
  input  wire        prog_mode,
  input  wire        sfr_wr,
  input  wire        sfr_rd,
  input  wire [7:0]  sfr_addr,
  input  wire [7:0]  sfr_wdata,
  output reg  [7:0]  sfr_rdata,
  // external data writes
  input  wire        xdata_wr,
  input  wire [15:0] xdata_addr,
  input  wire [7:0]  xdata_wdata,
  // code reads
  input  wire        code_rd,
  input  wire [15:0] code_addr,
  output reg  [7:0]  code_rdata,
  // configuration option
  input  wire        protect_region_enable,
  input  wire [1:0]  protect_size_sel,
  // cpu control
  output reg         cpu_stall,
  output reg         global_interrupt_block,
  // flash array port
  output reg         flash_erase,
  output reg         flash_write,
  output reg         flash_hard_lock,
  output reg         flash_refused,
  output reg  [19:0] flash_sector_addr,
  output reg  [DEPTH*8-1:0] flash_wdata,
  output reg  [DEPTH-1:0]   flash_byte_en,
  input  wire        flash_done,
  input  wire [7:0]  flash_rdata
);
  localparam ST_IDLE = 2'd0;
  localparam ST_RUN  = 2'd1;
  localparam ST_WAIT = 2'd2;

  reg [3:0]  addr_high_r;
  reg [7:0]  addr_mid_r;
  reg [7:0]  addr_low_r;
  reg [7:0]  operation_key_r;
  reg [2:0]  operation_select_field_r;
  reg        operation_busy_flag_r;
  reg [1:0]  state_r;
  reg [15:0] cnt_r;
  reg        pb_clear_r;

  wire [DEPTH*8-1:0] pb_data;
  wire [DEPTH-1:0]   pb_loaded;

  wire wr_ok   = sfr_wr && prog_mode;
  wire key_ok  = (operation_key_r == `FPEC_KEY_ARMED);
  wire ctl_wr  = wr_ok && sfr_addr == `FPEC_CTRL_ADDR;
  wire [2:0] op = sfr_wdata[`FPEC_OP_MSB:0];
  wire keyed_op = ctl_wr && key_ok && state_r == ST_IDLE &&
                  (op == `FPEC_OP_ERASE || op == `FPEC_OP_WRITE ||
                   op == `FPEC_OP_HARD_LOCK);
  wire [15:0] sect_addr16 = {addr_mid_r, addr_low_r};

  // protected region top per option
  reg [15:0] prot_top;
  always @* begin
    case (protect_size_sel)
      2'b00:   prot_top = `FPEC_PROT_TOP_00;
      2'b01:   prot_top = `FPEC_PROT_TOP_01;
      2'b10:   prot_top = `FPEC_PROT_TOP_10;
      default: prot_top = `FPEC_PROT_TOP_11;
    endcase
  end
  wire in_prot = protect_region_enable && addr_high_r == 4'h0 &&
                 sect_addr16 >= `FPEC_PROT_LOW &&
                 sect_addr16 <= prot_top;

  wire pb_hit = xdata_wr &&
                xdata_addr[15:AW] == `FPEC_PBUF_BASE_HI;

  fpec_page_buffer #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_pbuf (
    .core_clk    (core_clk),
    .nrst        (nrst),
    .clear_all   (pb_clear_r),
    .wr_en       (pb_hit),
    .wr_idx      (xdata_addr[AW-1:0]),
    .wr_data     (xdata_wdata),
    .data_flat   (pb_data),
    .loaded_flat (pb_loaded)
  );

  // address registers
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      addr_high_r <= 4'h0;
      addr_mid_r  <= `FPEC_REG_RESET;
      addr_low_r  <= `FPEC_REG_RESET;
    end else if (wr_ok) begin
      if (sfr_addr == `FPEC_SECT_HIGH_ADDR) begin
        addr_high_r <= sfr_wdata[3:0];
      end else if (sfr_addr == `FPEC_SECT_MID_ADDR) begin
        addr_mid_r <= sfr_wdata;
      end else if (sfr_addr == `FPEC_SECT_LOW_ADDR) begin
        addr_low_r <= sfr_wdata;
      end
    end
  end

  // key register
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      operation_key_r <= `FPEC_REG_RESET;
    end else if (ctl_wr && state_r == ST_IDLE && op != 3'h0) begin
      operation_key_r <= `FPEC_REG_RESET;
    end else if (wr_ok && sfr_addr == `FPEC_KEY_ADDR) begin
      operation_key_r <= sfr_wdata;
    end
  end

  // buffer clear pulse
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pb_clear_r <= 1'b0;
    end else begin
      pb_clear_r <= ctl_wr && state_r == ST_IDLE &&
                    op == `FPEC_OP_CLEAR_BUF;
    end
  end

  // operation sequencer
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r                  <= ST_IDLE;
      cnt_r                    <= 16'h0000;
      operation_select_field_r <= 3'h0;
      operation_busy_flag_r    <= 1'b0;
      cpu_stall                <= 1'b0;
      global_interrupt_block   <= 1'b0;
      flash_erase              <= 1'b0;
      flash_write              <= 1'b0;
      flash_hard_lock          <= 1'b0;
      flash_refused            <= 1'b0;
      flash_sector_addr        <= 20'h00000;
      flash_wdata              <= {DEPTH*8{1'b0}};
      flash_byte_en            <= {DEPTH{1'b0}};
    end else begin
      flash_erase     <= 1'b0;
      flash_write     <= 1'b0;
      flash_hard_lock <= 1'b0;
      flash_refused   <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          operation_select_field_r <= 3'h0;
          if (keyed_op) begin
            operation_select_field_r <= op;
            operation_busy_flag_r    <= 1'b1;
            cpu_stall                <= 1'b1;
            global_interrupt_block   <= 1'b1;
            flash_sector_addr <= {addr_high_r, sect_addr16};
            flash_wdata       <= pb_data;
            flash_byte_en     <= pb_loaded;
            cnt_r             <= OP_CYC[15:0];
            state_r           <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (operation_select_field_r == `FPEC_OP_HARD_LOCK) begin
            flash_hard_lock <= 1'b1;
          end else if (in_prot) begin
            flash_refused <= 1'b1;
          end else if (operation_select_field_r == `FPEC_OP_ERASE) begin
            flash_erase <= 1'b1;
          end else begin
            flash_write <= 1'b1;
          end
          state_r <= ST_WAIT;
        end
        default: begin
          if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
          end
          if (cnt_r == 16'h0000 || flash_done) begin
            operation_select_field_r <= 3'h0;
            operation_busy_flag_r    <= 1'b0;
            cpu_stall                <= 1'b0;
            global_interrupt_block   <= 1'b0;
            state_r                  <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // register read path
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd && prog_mode) begin
      if (sfr_addr == `FPEC_SECT_HIGH_ADDR) begin
        sfr_rdata <= {4'h0, addr_high_r};
      end else if (sfr_addr == `FPEC_SECT_MID_ADDR) begin
        sfr_rdata <= addr_mid_r;
      end else if (sfr_addr == `FPEC_SECT_LOW_ADDR) begin
        sfr_rdata <= addr_low_r;
      end else if (sfr_addr == `FPEC_KEY_ADDR) begin
        sfr_rdata <= operation_key_r;
      end else if (sfr_addr == `FPEC_CTRL_ADDR) begin
        sfr_rdata <= {operation_busy_flag_r, 4'h0,
                      operation_select_field_r};
      end else begin
        sfr_rdata <= 8'h00;
      end
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // code read path
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      code_rdata <= 8'h00;
    end else if (code_rd) begin
      code_rdata <= flash_rdata;
    end
  end
endmodule

// ===== fpec_ctrl_props.sv
`timescale 1ns/1ns
module fpec_ctrl_props (
  // clock and reset
  input wire       core_clk,
  input wire       nrst,
  // watched ports
  input wire       prog_mode,
  input wire       sfr_wr,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire       cpu_stall,
  input wire       global_interrupt_block,
  input wire       flash_write,
  input wire       flash_hard_lock,
  input wire       flash_refused
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_key;
    sfr_wr && prog_mode && sfr_addr == 8'hfd && sfr_wdata == 8'ha5;
  endsequence
  sequence s_start(op);
    sfr_wr && prog_mode && sfr_addr == 8'hfe && sfr_wdata[2:0] == op;
  endsequence
  a_keyed_write: assert property (
    s_key ##2 s_start(3'h3) |=> cpu_stall ##1 (flash_write || flash_refused))
    else $error("keyed write did not start");
  a_irq_blocked: assert property (
    cpu_stall == global_interrupt_block)
    else $error("interrupt block differs from stall");
  a_op_stalled: assert property (
    (flash_write || flash_hard_lock) |-> cpu_stall)
    else $error("flash pulse outside stall");
  a_write_pulse: assert property (flash_write |=> !flash_write)
    else $error("write pulse too long");
  a_stall_ends: assert property (
    $rose(cpu_stall) |-> ##[3:300] !cpu_stall)
    else $error("stall did not end");
  a_no_prog: assert property (
    sfr_wr && !prog_mode && !cpu_stall |=> !cpu_stall)
    else $error("write taken outside programming mode");
  a_clear_idle: assert property (
    s_start(3'h1) and !cpu_stall |=> !cpu_stall)
    else $error("buffer clear stalled the cpu");
  a_refuse_excl: assert property (flash_refused |-> !flash_write)
    else $error("refused operation still wrote");
endmodule
bind fpec_ctrl fpec_ctrl_props u_props (.core_clk, .nrst, .prog_mode, .sfr_wr,
  .sfr_addr, .sfr_wdata, .cpu_stall, .global_interrupt_block, .flash_write,
  .flash_hard_lock, .flash_refused);

// ===== fpec_flash_model.sv
`timescale 1ns/1ns
module fpec_flash_model (
  // clock, reset, pace
  input  wire         core_clk,
  input  wire         nrst,
  input  wire         slow,
  // flash array port
  input  wire         flash_erase,
  input  wire         flash_write,
  input  wire         flash_hard_lock,
  input  wire [511:0] flash_wdata,
  input  wire [63:0]  flash_byte_en,
  input  wire         code_rd,
  input  wire [15:0]  code_addr,
  output wire [7:0]   flash_rdata,
  output reg          flash_done
);
  reg [7:0] mem [0:63];
  reg [1:0] cnt_r;
  integer   i;
  // outside a read the data lines show the inverse
  assign flash_rdata = code_rd ? mem[code_addr[5:0]] : ~mem[code_addr[5:0]];
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 2'h0;
      flash_done <= 1'b0;
      for (i = 0; i < 64; i = i + 1)
        mem[i] <= 8'hff;
    end else begin
      flash_done <= cnt_r == 2'h1 && !slow;
      if (cnt_r != 2'h0)
        cnt_r <= cnt_r - 2'h1;
      if (flash_erase || flash_write || flash_hard_lock)
        cnt_r <= 2'h3;
      for (i = 0; i < 64; i = i + 1)
        if ((flash_erase || flash_write) && flash_byte_en[i])
          mem[i] <= flash_wdata[8*i+:8];
    end
  end
endmodule

// ===== flash_program_erase_control_tb_top.sv
`timescale 1ns/1ns
module flash_program_erase_control_tb_top;
  reg          core_clk, nrst, prog_mode, sfr_wr, sfr_rd, xdata_wr, code_rd;
  reg          protect_region_enable, slow;
  reg  [1:0]   protect_size_sel;
  reg  [7:0]   sfr_addr, sfr_wdata, xdata_wdata;
  reg  [15:0]  xdata_addr, code_addr;
  wire [7:0]   sfr_rdata, code_rdata, flash_rdata;
  wire         cpu_stall, global_interrupt_block, flash_erase, flash_write;
  wire         flash_hard_lock, flash_refused, flash_done;
  wire [19:0]  flash_sector_addr;
  wire [511:0] flash_wdata;
  wire [63:0]  flash_byte_en;
  integer      fail_count, checks, n_ref, n_lock, i;
  fpec_ctrl #(.OP_CYC(5)) uut (.core_clk, .nrst, .prog_mode, .sfr_wr, .sfr_rd,
    .sfr_addr, .sfr_wdata, .sfr_rdata, .xdata_wr, .xdata_addr, .xdata_wdata,
    .code_rd, .code_addr, .code_rdata, .protect_region_enable,
    .protect_size_sel, .cpu_stall, .global_interrupt_block, .flash_erase,
    .flash_write, .flash_hard_lock, .flash_refused, .flash_sector_addr,
    .flash_wdata, .flash_byte_en, .flash_done, .flash_rdata);
  fpec_flash_model fm (.core_clk, .nrst, .slow, .flash_erase, .flash_write,
    .flash_hard_lock, .flash_wdata, .flash_byte_en, .code_rd, .code_addr,
    .flash_rdata, .flash_done);
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    n_ref <= n_ref + flash_refused;
    n_lock <= n_lock + flash_hard_lock;
  end
  task chk(input [7:0] g, input [7:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge core_clk);
    sfr_wr <= 1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge core_clk);
    sfr_wr <= 0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge core_clk);
    sfr_rd <= 1;
    sfr_addr <= a;
    @(posedge core_clk);
    sfr_rd <= 0;
    #1 chk(sfr_rdata, e);
  endtask
  task xw(input [15:0] a, input [7:0] d);
    @(posedge core_clk);
    xdata_wr <= 1;
    xdata_addr <= a;
    xdata_wdata <= d;
    @(posedge core_clk);
    xdata_wr <= 0;
  endtask
  task cr(input [15:0] a, input [7:0] e);
    @(posedge core_clk);
    code_rd <= 1;
    code_addr <= a;
    @(posedge core_clk);
    code_rd <= 0;
    #1 chk(code_rdata, e);
  endtask
  task op(input [7:0] k, input [7:0] o, input [7:0] st);
    wr(8'hfd, k);
    wr(8'hfe, o);
    #1 chk(cpu_stall, st);
    chk(global_interrupt_block, st);
  endtask
  task idle;
    integer n;
    n = 0;
    while (cpu_stall !== 1'b0 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    #1 chk(cpu_stall, 0);
  endtask
  task stop_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    stop_test;
  end
  initial begin
    {fail_count, checks, n_ref, n_lock} = 0;
    {nrst, prog_mode, sfr_wr, sfr_rd, xdata_wr, code_rd, slow} = 0;
    {protect_region_enable, protect_size_sel, xdata_addr, code_addr} = 0;
    {sfr_addr, sfr_wdata, xdata_wdata} = 0;
    repeat (6) @(posedge core_clk);
    nrst <= 1;
    wr(8'hfb, 8'h33);
    prog_mode <= 1;
    for (i = 0; i < 5; i++) rd(8'hfa + i, 8'h00);
    wr(8'hfa, 8'hff);
    rd(8'hfa, 8'h0f);
    op(8'h00, 8'h81, 0);
    rd(8'hfe, 8'h00);
    xw(16'h8000, 8'h05);
    xw(16'h8005, 8'h06);
    xw(16'h8040, 8'h77);
    wr(8'hfa, 8'h00);
    wr(8'hfb, 8'h7f);
    wr(8'hfc, 8'h40);
    op(8'ha5, 8'h03, 1);
    idle;
    chk(flash_sector_addr[15:8], 8'h7f);
    chk(flash_sector_addr[7:0], 8'h40);
    rd(8'hfd, 8'h00);
    rd(8'hfe, 8'h00);
    cr(16'h0000, 8'h05);
    cr(16'h0005, 8'h06);
    cr(16'h0001, 8'hff);
    op(8'h5a, 8'h02, 0);
    op(8'ha5, 8'h05, 0);
    rd(8'hfd, 8'h00);
    op(8'h00, 8'h01, 0);
    xw(16'h8005, 8'h00);
    slow <= 1;
    op(8'ha5, 8'h02, 1);
    rd(8'hfe, 8'h82);
    idle;
    slow <= 0;
    cr(16'h0005, 8'h00);
    cr(16'h0000, 8'h05);
    op(8'ha5, 8'h04, 1);
    idle;
    chk(n_lock, 1);
    protect_region_enable <= 1;
    wr(8'hfb, 8'h01);
    wr(8'hfc, 8'h80);
    op(8'h00, 8'h01, 0);
    xw(16'h8000, 8'haa);
    op(8'ha5, 8'h03, 1);
    idle;
    chk(n_ref, 1);
    cr(16'h0000, 8'h05);
    wr(8'hfb, 8'h02);
    wr(8'hfc, 8'h00);
    for (i = 0; i < 4; i++) begin
      protect_size_sel <= i[1:0];
      op(8'ha5, 8'h03, 1);
      idle;
      chk(n_ref, i < 3 ? i + 2 : 4);
    end
    cr(16'h0000, 8'haa);
    protect_region_enable <= 0;
    protect_size_sel <= 0;
    wr(8'hfb, 8'h01);
    xw(16'h8001, 8'h11);
    op(8'ha5, 8'h03, 1);
    idle;
    chk(n_ref, 4);
    cr(16'h0001, 8'h11);
    stop_test;
  end
endmodule
